// ==== common/epp17_pkg.sv ====
// Constants and types shared by the EPP 1.7 cycle engine
package epp17_pkg;
   // Host register offsets from the port base
   localparam logic [2:0] OFS_SPP_DATA  = 3'h0;
   localparam logic [2:0] OFS_STATUS    = 3'h1;
   localparam logic [2:0] OFS_CONTROL   = 3'h2;
   localparam logic [2:0] OFS_EPP_ADDR  = 3'h3;
   localparam logic [2:0] OFS_EPP_DATA0 = 3'h4;
   localparam logic [2:0] OFS_EPP_DATA3 = 3'h7;
   // Control register field positions
   localparam int CTL_STROBE_BIT  = 0;
   localparam int CTL_AUTOFD_BIT  = 1;
   localparam int CTL_INIT_BIT    = 2;
   localparam int CTL_SELIN_BIT   = 3;
   localparam int CTL_DIR_BIT     = 5;
   // Status register field positions
   localparam int STS_TIMEOUT_BIT = 0;
   // Reset values
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] CTL_RESET  = 8'h04;
   // Watchdog time
   localparam int CLK_PERIOD_NS   = 10;
   localparam int TIMEOUT_US      = 10;
   localparam int TIMEOUT_CYCLES  = (TIMEOUT_US * 1000) / CLK_PERIOD_NS;
   localparam int TMR_W           = 11;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_STROBE = 2'b01,
      ST_DONE   = 2'b11
   } cycle_state_t;
endpackage : epp17_pkg

// ==== common/epp_wdog_if.sv ====
// Watchdog link between the cycle engine and its timer
interface epp_wdog_if;
   logic run;
   logic expired;
   modport engine (output run, input expired);
   modport timer  (input run, output expired);
endinterface : epp_wdog_if

// ==== design/epp17_parallel_cycle_engine.sv ====
// EPP 1.7 parallel port cycle engine behind the ISA host interface
// What this block does
// - IOCHRDY held low while a cycle runs and peripheral wait is low.
// - Write cycle finishes only after peripheral wait returns high.
// - Read cycle finishes only after peripheral wait returns high.
// - Host sets direction bit before read; indicator deasserts, bus floats.
// - Host write to EPP register drives the byte onto the port bus.
// - Write strobe asserts only after port data and write indicator settle.
// - IOCHRDY stays low until wait releases or the time-out expires.
// - nIOW release drops the strobe and latches host data for port.
// - Read strobe asserts with bus floating, direction high, indicator valid.
// - nIOR release drops whichever strobe is active.
// - Indicator and direction change only while no strobe is active; port data takes the host byte as soon as nIOW is active.
// - Write indicator, strobes and peripheral reset are active low.
// - Peripheral interrupt is active high, passed through uninverted.
// - Asserted peripheral reset returns the peripheral to its initial mode.
// - Direction output low for write, high only on direction bit or read.
// - Control strobe bit overrides the write indicator; direction bit overrides direction and bus float.
// - Standard port and EPP share one common data register.
// - Cycle over 10 us aborts and sets status bit 0.
// - EPP data ports at offsets 04H to 07H, cleared by reset.
module epp17_parallel_cycle_engine (
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   // ISA host side
   input  wire logic       i_host_ior_n,
   input  wire logic       i_host_iow_n,
   input  wire logic [2:0] i_host_addr,
   input  wire logic [7:0] i_host_data_bus,
   output logic      [7:0] o_host_data_bus,
   output logic            o_host_data_oe_n,
   output logic            o_iochrdy,
   // Mode
   input  wire logic       i_epp_enable,
   // Parallel port side
   input  wire logic [7:0] i_port_data_bus,
   output logic      [7:0] o_port_data_bus,
   output logic            o_port_data_oe_n,
   output logic            o_bus_direction_out,
   output logic            o_write_indicator_n,
   output logic            o_data_strobe_n,
   output logic            o_addr_strobe_n,
   output logic            o_periph_reset_n,
   input  wire logic       i_periph_wait_n,
   input  wire logic       i_periph_interrupt,
   output logic            o_periph_interrupt,
   // Status
   output logic            o_timeout_flag
);
   // Pin synchronisers
   logic       ior_m, ior_s, iow_m, iow_s, wait_m, wait_s, periph_interrupt_m, periph_interrupt_s;
   logic [7:0] port_data_bus_m, port_data_bus_s;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         ior_m   <= 1'b1;
         ior_s   <= 1'b1;
         iow_m   <= 1'b1;
         iow_s   <= 1'b1;
         wait_m  <= 1'b1;
         wait_s  <= 1'b1;
         periph_interrupt_m  <= 1'b0;
         periph_interrupt_s  <= 1'b0;
         port_data_bus_m <= 8'h00;
         port_data_bus_s <= 8'h00;
      end else begin
         ior_m   <= i_host_ior_n;
         ior_s   <= ior_m;
         iow_m   <= i_host_iow_n;
         iow_s   <= iow_m;
         wait_m  <= i_periph_wait_n;
         wait_s  <= wait_m;
         periph_interrupt_m  <= i_periph_interrupt;
         periph_interrupt_s  <= periph_interrupt_m;
         port_data_bus_m <= i_port_data_bus;
         port_data_bus_s <= port_data_bus_m;
      end
   end

   // Host address and data take the same two stages as the strobes,
   // so the offset decode never runs ahead of the strobe it qualifies
   logic [2:0] addr_m, addr_s;
   logic [7:0] hdata_m, hdata_s;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         addr_m  <= 3'h0;
         addr_s  <= 3'h0;
         hdata_m <= 8'h00;
         hdata_s <= 8'h00;
      end else begin
         addr_m  <= i_host_addr;
         addr_s  <= addr_m;
         hdata_m <= i_host_data_bus;
         hdata_s <= hdata_m;
      end
   end

   // Interrupt passes through without inversion
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) o_periph_interrupt <= 1'b0;
      else       o_periph_interrupt <= periph_interrupt_s;
   end

   // Host decode
   logic ior_act, iow_act, host_act, epp_reg, is_addr_reg, host_act_q;
   assign ior_act     = !ior_s;
   assign iow_act     = !iow_s;
   assign host_act    = ior_act || iow_act;
   assign is_addr_reg = (addr_s == epp17_pkg::OFS_EPP_ADDR);
   assign epp_reg     = i_epp_enable && (is_addr_reg || addr_s >= epp17_pkg::OFS_EPP_DATA0);

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) host_act_q <= 1'b0;
      else       host_act_q <= host_act;
   end

   // Shared data register, control register, timeout status
   logic [7:0] data_reg, ctl_reg;
   logic       host_wr_edge, was_write;
   assign host_wr_edge = host_act_q && !host_act && was_write;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) was_write <= 1'b0;
      else if (host_act) was_write <= iow_act;
   end

   // Trailing edge of a write latches the host byte
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         data_reg <= epp17_pkg::DATA_RESET;
      end else if (host_wr_edge && (epp_reg || addr_s == epp17_pkg::OFS_SPP_DATA)) begin
         data_reg <= hdata_s;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) ctl_reg <= epp17_pkg::CTL_RESET;
      else if (host_wr_edge && addr_s == epp17_pkg::OFS_CONTROL) ctl_reg <= hdata_s;
   end

   // Cycle engine
   epp17_pkg::cycle_state_t state;
   epp_wdog_if wd_if ();
   logic cyc_read, strobe_addr, wd_hit;

   epp_cycle_watchdog u_wdog (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .wd        (wd_if.timer)
   );
   assign wd_if.run = (state != epp17_pkg::ST_IDLE) && host_act;
   assign wd_hit    = wd_if.expired;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state       <= epp17_pkg::ST_IDLE;
         cyc_read    <= 1'b0;
         strobe_addr <= 1'b0;
      end else begin
         unique case (state)
            epp17_pkg::ST_IDLE: begin
               if (host_act && epp_reg) begin
                  state       <= epp17_pkg::ST_STROBE;
                  cyc_read    <= ior_act;
                  strobe_addr <= is_addr_reg;
               end
            end
            epp17_pkg::ST_STROBE: begin
               // Abort drops the strobe; the host strobe still ends the cycle
               if (!host_act || wd_hit) state <= epp17_pkg::ST_DONE;
            end
            epp17_pkg::ST_DONE: begin
               if (!host_act) state <= epp17_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Strobes one cycle after bus and indicator are set up
   logic setup_done;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) setup_done <= 1'b0;
      else       setup_done <= (state == epp17_pkg::ST_STROBE) && host_act && !wd_hit;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_data_strobe_n <= 1'b1;
         o_addr_strobe_n <= 1'b1;
      end else begin
         o_data_strobe_n <= !(setup_done && host_act && !wd_hit && !strobe_addr);
         o_addr_strobe_n <= !(setup_done && host_act && !wd_hit && strobe_addr);
      end
   end

   // Ready stretches the host while the peripheral waits
   logic stretch;
   assign stretch = (state == epp17_pkg::ST_STROBE) && !wait_s && !wd_hit;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) o_iochrdy <= 1'b1;
      else       o_iochrdy <= !stretch;
   end

   // Timeout flag: set wins over clear on a status read
   logic sts_rd_edge;
   assign sts_rd_edge = host_act_q && !host_act && !was_write && addr_s == epp17_pkg::OFS_STATUS;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst)        o_timeout_flag <= 1'b0;
      else if (wd_hit)  o_timeout_flag <= 1'b1;
      else if (sts_rd_edge) o_timeout_flag <= 1'b0;
   end

   // Read data captured while the strobe is active
   logic [7:0] rd_latch;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) rd_latch <= 8'h00;
      else if (state == epp17_pkg::ST_STROBE && cyc_read && wait_s)
         rd_latch <= port_data_bus_s;
   end

   // Host data bus answer
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_host_data_bus  <= 8'h00;
         o_host_data_oe_n <= 1'b1;
      end else begin
         o_host_data_oe_n <= !ior_act;
         unique case (addr_s)
            epp17_pkg::OFS_SPP_DATA: o_host_data_bus <= data_reg;
            epp17_pkg::OFS_STATUS:   o_host_data_bus <= {7'h00, o_timeout_flag};
            epp17_pkg::OFS_CONTROL:  o_host_data_bus <= ctl_reg;
            default:                 o_host_data_bus <= rd_latch;
         endcase
      end
   end

   // Port pins: direction and indicator change only while no strobe is active; a read raises direction at cycle start
   logic port_direction_ctl, rd_cycle_live;
   assign port_direction_ctl           = ctl_reg[epp17_pkg::CTL_DIR_BIT];
   assign rd_cycle_live = (state != epp17_pkg::ST_IDLE) && cyc_read;

   // Live host byte for the whole write; the shared register takes over
   // only once the cycle has ended, so the byte never slips back mid-cycle
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_port_data_bus <= 8'h00;
      end else if (iow_act && (epp_reg || addr_s == epp17_pkg::OFS_SPP_DATA)) begin
         o_port_data_bus <= hdata_s;
      end else if (state == epp17_pkg::ST_IDLE && !host_act_q) begin
         o_port_data_bus <= data_reg;
      end
   end

   // Direction and bus float follow the direction bit or a live read
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_bus_direction_out <= 1'b0;
         o_port_data_oe_n    <= 1'b0;
      end else begin
         o_bus_direction_out <= port_direction_ctl || rd_cycle_live;
         o_port_data_oe_n    <= port_direction_ctl || rd_cycle_live;
      end
   end

   // Only the control strobe bit overrides the indicator
   logic write_mode;
   assign write_mode = (!port_direction_ctl && !rd_cycle_live) || ctl_reg[epp17_pkg::CTL_STROBE_BIT];
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) o_write_indicator_n <= 1'b1;
      else       o_write_indicator_n <= !write_mode;
   end

   // Peripheral reset from the control init bit, low active
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) o_periph_reset_n <= 1'b0;
      else       o_periph_reset_n <= ctl_reg[epp17_pkg::CTL_INIT_BIT];
   end
endmodule : epp17_parallel_cycle_engine

// ==== design/epp_cycle_watchdog.sv ====
// Cycle length watchdog for EPP host cycles
module epp_cycle_watchdog (
   // Clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_rst,
   // Engine link
   epp_wdog_if.timer wd
);
   logic [epp17_pkg::TMR_W-1:0] count;

   // Count while a host strobe is held, restart on each new cycle
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || !wd.run) begin
         count      <= '0;
         wd.expired <= 1'b0;
      end else if (count >= epp17_pkg::TMR_W'(epp17_pkg::TIMEOUT_CYCLES)) begin
         wd.expired <= 1'b1;
      end else begin
         count <= count + 1'b1;
      end
   end
endmodule : epp_cycle_watchdog

// ==== verification/epp17_cycle_engine_asserts.sv ====
// Port-level concurrent checks for the EPP 1.7 cycle engine
module epp17_cycle_engine_asserts (
   // Clock and reset
   input wire logic       i_sys_clk,
   input wire logic       i_rst,
   // Host side
   input wire logic       i_host_ior_n,
   input wire logic       i_host_iow_n,
   input wire logic [2:0] i_host_addr,
   input wire logic       o_iochrdy,
   // Port side
   input wire logic       i_periph_wait_n,
   input wire logic       i_periph_interrupt,
   input wire logic       o_periph_interrupt,
   input wire logic       o_port_data_oe_n,
   input wire logic       o_bus_direction_out,
   input wire logic       o_write_indicator_n,
   input wire logic       o_data_strobe_n,
   input wire logic       o_addr_strobe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [10:0] strobe_cycles;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // Counter, since a repetition cannot reach the watchdog length
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || (o_data_strobe_n && o_addr_strobe_n)) strobe_cycles <= 11'h000;
      else strobe_cycles <= strobe_cycles + 11'h001;
   end
   sequence strobe_on; !o_data_strobe_n || !o_addr_strobe_n; endsequence
   sequence strobe_held; strobe_on ##1 strobe_on; endsequence
   sequence host_release; $rose(i_host_ior_n) || $rose(i_host_iow_n); endsequence
   a_iochrdy_release: assert property (
      i_periph_wait_n [*4] |-> o_iochrdy) else $error("iochrdy low after wait released");
   a_stretch_hold: assert property (
      ((!o_data_strobe_n || !o_addr_strobe_n) && !i_periph_wait_n && strobe_cycles < 11'h3C0) [*5]
      |-> !o_iochrdy) else $error("iochrdy high while wait low");
   a_write_setup: assert property (
      $fell(o_data_strobe_n && o_addr_strobe_n) && !o_bus_direction_out
      |-> $past(!o_port_data_oe_n) && $past(!o_write_indicator_n)) else $error("write strobe early");
   a_read_float: assert property (
      $fell(o_data_strobe_n && o_addr_strobe_n) && o_bus_direction_out
      |-> o_port_data_oe_n && $past(o_port_data_oe_n) && o_write_indicator_n)
      else $error("read strobe with bus driven");
   a_strobe_release: assert property (
      host_release |-> ##[1:6] (o_data_strobe_n && o_addr_strobe_n)) else $error("strobe stuck");
   a_pins_steady: assert property (
      strobe_held |-> $stable(o_bus_direction_out) && $stable(o_write_indicator_n)
      && $stable(o_port_data_oe_n)) else $error("port controls moved mid cycle");
   a_periph_interrupt_follow: assert property (
      $stable(i_periph_interrupt) [*4] |-> o_periph_interrupt == i_periph_interrupt)
      else $error("interrupt not passed through");
   a_addr_select: assert property (
      $fell(o_addr_strobe_n) |-> i_host_addr == epp17_pkg::OFS_EPP_ADDR)
      else $error("address strobe on data offset");
   a_data_select: assert property (
      $fell(o_data_strobe_n) |-> i_host_addr[2]) else $error("data strobe on wrong offset");
   a_watchdog_bound: assert property (
      strobe_cycles < 11'h3F4) else $error("cycle outlived watchdog");
endmodule // epp17_cycle_engine_asserts

// ==== verification/epp17_parallel_cycle_engine_tb_top.sv ====
// Self-checking bench for the EPP 1.7 cycle engine
module epp17_parallel_cycle_engine_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_sys_clk, i_rst, i_host_ior_n, i_host_iow_n, o_host_data_oe_n, o_iochrdy, i_epp_enable;
   logic o_port_data_oe_n, o_bus_direction_out, o_write_indicator_n, o_data_strobe_n;
   logic o_addr_strobe_n, o_periph_reset_n, i_periph_wait_n, i_periph_interrupt;
   logic o_periph_interrupt, o_timeout_flag, res_evt, per_done;
   logic [2:0] i_host_addr;
   logic [7:0] i_host_data_bus, o_host_data_bus, i_port_data_bus, o_port_data_bus, per_drive;
   logic [7:0] per_got, rd_byte, delay, q, d, e, a, res_val;
   logic [7:0] exp_q[$];
   int         miscompares, checks, seed, n;
   assign i_port_data_bus = o_port_data_oe_n ? per_drive : o_port_data_bus;
   epp17_parallel_cycle_engine dut (.i_sys_clk, .i_rst, .i_host_ior_n, .i_host_iow_n, .i_host_addr,
      .i_host_data_bus, .o_host_data_bus, .o_host_data_oe_n, .o_iochrdy, .i_epp_enable,
      .i_port_data_bus, .o_port_data_bus, .o_port_data_oe_n, .o_bus_direction_out,
      .o_write_indicator_n, .o_data_strobe_n, .o_addr_strobe_n, .o_periph_reset_n,
      .i_periph_wait_n, .i_periph_interrupt, .o_periph_interrupt, .o_timeout_flag);
   epp_periph_model per (.i_sys_clk, .i_data_strobe_n(o_data_strobe_n),
      .i_addr_strobe_n(o_addr_strobe_n), .i_write_indicator_n(o_write_indicator_n),
      .i_bus(i_port_data_bus), .i_rd_byte(rd_byte), .i_delay(delay), .o_wait_n(i_periph_wait_n),
      .o_drive(per_drive), .o_done(per_done), .o_got(per_got));
   task automatic close_out();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic obs(input logic [7:0] v);
      @(posedge i_sys_clk);
      #1 res_val = v;
      res_evt = 1'b1;
      @(posedge i_sys_clk);
      #1 res_evt = 1'b0;
   endtask
   task automatic host_cyc(input logic wr, input logic [2:0] ofs, input logic [7:0] wd);
      @(posedge i_sys_clk);
      #1 {i_host_addr, i_host_data_bus, i_host_iow_n, i_host_ior_n} = {ofs, wd, !wr, wr};
      repeat (8) @(posedge i_sys_clk);
      // Outputs are looked at just after the edge, once settled
      #1;
      for (n = 0; n < 1200 && o_iochrdy !== 1'b1; n++) begin
         @(posedge i_sys_clk);
         #1;
      end
      if (n == 1200) begin
         miscompares++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, 1'b1, o_iochrdy);
         close_out();
      end
      repeat (2) @(posedge i_sys_clk);
      #1 q = o_host_data_bus;
      {i_host_iow_n, i_host_ior_n} = 2'h3;
      repeat (8) @(posedge i_sys_clk);
   endtask
   // Results pair with notes in issue order
   always @(posedge i_sys_clk) begin
      if (res_evt || per_done) begin
         checks++;
         e = exp_q.size() ? exp_q.pop_front() : 8'hXX;
         a = per_done ? per_got : res_val;
         if (e !== a) begin
            miscompares++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
         end
      end
   end
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      {seed, i_rst, i_host_ior_n, i_host_iow_n, i_epp_enable} = {32'h65DD, 4'hF};
      {i_host_addr, i_host_data_bus, i_periph_interrupt, res_evt, rd_byte, delay} = 29'h0000002;
      repeat (5) @(posedge i_sys_clk);
      exp_q.push_back(8'hBC);
      obs({o_host_data_oe_n, o_timeout_flag, o_data_strobe_n, o_addr_strobe_n, o_iochrdy,
           o_write_indicator_n,
           o_bus_direction_out, o_periph_reset_n});
      repeat (3) @(posedge i_sys_clk);
      #1 i_rst = 1'b0;
      repeat (3) @(posedge i_sys_clk);
      $display("reset test done");
      host_cyc(1'b1, epp17_pkg::OFS_CONTROL, epp17_pkg::CTL_RESET);
      for (int k = 3; k < 8; k++) begin
         delay = 8'h02 + 8'({$random(seed)} % 14);
         d = 8'($random(seed));
         exp_q.push_back(d);
         host_cyc(1'b1, 3'(k), d);
      end
      $display("write test done");
      host_cyc(1'b1, epp17_pkg::OFS_CONTROL, epp17_pkg::CTL_RESET | 8'h20);
      for (int k = 3; k < 8; k++) begin
         delay = 8'h02 + 8'({$random(seed)} % 14);
         rd_byte = 8'($random(seed));
         exp_q.push_back(rd_byte);
         host_cyc(1'b0, 3'(k), 8'h00);
         obs(q);
      end
      $display("read test done");
      for (int k = 0; k < 2; k++) begin
         @(posedge i_sys_clk);
         #1 i_periph_interrupt = !i_periph_interrupt;
         repeat (5) @(posedge i_sys_clk);
         exp_q.push_back(8'(k == 0));
         obs({7'h00, o_periph_interrupt});
      end
      $display("interrupt test done");
      host_cyc(1'b1, epp17_pkg::OFS_CONTROL, epp17_pkg::CTL_RESET);
      delay = 8'hFF;
      host_cyc(1'b1, epp17_pkg::OFS_EPP_DATA0, 8'h5A);
      exp_q.push_back(8'h01);
      obs({7'h00, o_timeout_flag});
      delay = 8'h02;
      host_cyc(1'b0, epp17_pkg::OFS_STATUS, 8'h00);
      exp_q.push_back(8'h01);
      obs(q & 8'h01);
      exp_q.push_back(8'h00);
      obs({7'h00, o_timeout_flag});
      $display("timeout test done");
      close_out();
   end
endmodule // epp17_parallel_cycle_engine_tb_top
bind epp17_parallel_cycle_engine epp17_cycle_engine_asserts u_chk (.i_sys_clk, .i_rst,
   .i_host_ior_n, .i_host_iow_n, .i_host_addr, .o_iochrdy, .i_periph_wait_n, .i_periph_interrupt,
   .o_periph_interrupt, .o_port_data_oe_n, .o_bus_direction_out, .o_write_indicator_n,
   .o_data_strobe_n, .o_addr_strobe_n);

// ==== verification/epp_periph_model.sv ====
// Behavioural EPP peripheral on the far side of the port
module epp_periph_model (
   // Clock
   input  wire logic       i_sys_clk,
   // From the engine
   input  wire logic       i_data_strobe_n,
   input  wire logic       i_addr_strobe_n,
   input  wire logic       i_write_indicator_n,
   input  wire logic [7:0] i_bus,
   // Test control, delay 8'hFF never answers
   input  wire logic [7:0] i_rd_byte,
   input  wire logic [7:0] i_delay,
   // Answers
   output logic            o_wait_n,
   output logic [7:0]      o_drive,
   output logic            o_done,
   output logic [7:0]      o_got
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       act, latched, drv;
   logic [7:0] cnt;
   initial begin
      {act, latched, drv, o_wait_n, o_done} = 5'h00;
      {cnt, o_got, o_drive} = {16'h0000, 8'hA5};
   end
   always @(posedge i_sys_clk) begin
      o_done <= 1'b0;
      // Floating bus must not look like held data
      if (!drv) o_drive <= ~o_drive;
      if (i_data_strobe_n && i_addr_strobe_n) begin
         o_done   <= act && latched && !i_write_indicator_n;
         {act, latched, drv} <= 3'h0;
         o_wait_n <= 1'b0;
      end else if (!act) begin
         act <= 1'b1;
         cnt <= i_delay;
      end else if (cnt == 8'h01 && i_write_indicator_n) begin
         drv     <= 1'b1;
         o_drive <= i_rd_byte;
         cnt     <= 8'h00;
      end else if (cnt != 8'h00 && cnt != 8'hFF) begin
         cnt <= cnt - 8'h01;
      end else if (cnt == 8'h00) begin
         latched  <= 1'b1;
         o_got    <= i_bus;
         o_wait_n <= 1'b1;
      end
   end
endmodule // epp_periph_model
